// ### include/nv_access_pkg.sv
package nv_access_pkg;

  ////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CLK_PERIOD_NS      = 20;
  localparam int NS_PER_US          = 1000;
  localparam int WRITE_TIME_US      = 4000;
  localparam int WRITE_CYCLES_DEF   =
    (WRITE_TIME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWERUP_TIME_US    = 1000;
  localparam int POWERUP_CYCLES_DEF =
    (POWERUP_TIME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W            = 18;
  localparam int PWRUP_W            = 16;

  ////////////////////////////////////////////////////////////
  // Array and bus geometry
  localparam int BYTE_W    = 8;
  localparam int ADDR_W    = 10;
  localparam int ADDR_LO_W = 8;
  localparam int ADDR_HI_W = ADDR_W - ADDR_LO_W;
  localparam int DEPTH     = 1024;
  localparam int WB_DW     = 32;
  localparam int WB_AW     = 6;
  localparam int WB_SW     = 4;
  localparam int IDX_LO    = 2;
  localparam int IDX_W     = WB_AW - IDX_LO;
  localparam int BYTE_LANE = 0;

  ////////////////////////////////////////////////////////////
  // Register word indices, byte address is four times these
  localparam logic [IDX_W-1:0] REG_CTL       = 4'h0;
  localparam logic [IDX_W-1:0] REG_UNLOCK    = 4'h1;
  localparam logic [IDX_W-1:0] REG_DATA      = 4'h2;
  localparam logic [IDX_W-1:0] REG_ADDR_LO   = 4'h3;
  localparam logic [IDX_W-1:0] REG_ADDR_HI   = 4'h4;
  localparam logic [IDX_W-1:0] REG_IRQ_FLAGS = 4'h5;
  localparam logic [IDX_W-1:0] REG_IRQ_EN    = 4'h6;
  localparam logic [IDX_W-1:0] REG_IRQ_PRIO  = 4'h7;

  ////////////////////////////////////////////////////////////
  // Field positions and keys
  localparam int CTL_RD       = 0;
  localparam int CTL_WR       = 1;
  localparam int CTL_WEN      = 2;
  localparam int CTL_ERR      = 3;
  localparam int CTL_ROW      = 4;
  localparam int CTL_CFG      = 6;
  localparam int CTL_MEM      = 7;
  localparam int IRQ_DONE_BIT = 4;
  localparam logic [BYTE_W-1:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [BYTE_W-1:0] UNLOCK_KEY2 = 8'hAA;

  ////////////////////////////////////////////////////////////
  // Types
  typedef logic [BYTE_W-1:0] byte_t;

  typedef enum logic [1:0] {
    UNLOCK_IDLE,
    UNLOCK_HALF,
    UNLOCK_ARMED
  } unlock_e;

  typedef struct packed {
    logic memory_select;
    logic config_select;
    logic row_erase;
    logic write_error_flag;
    logic write_enable_flag;
    logic write_start;
    logic read_start;
  } ctl_s;

  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    byte_t             wdata;
  } nv_req_s;

  typedef struct packed {
    ctl_s               ctl;
    unlock_e            unlock;
    byte_t              data;
    logic [ADDR_W-1:0]  addr;
    logic               irq_flag;
    logic               irq_en;
    logic               irq_prio;
    logic [PWRUP_W-1:0] pwr_cnt;
    logic               pwr_ok;
    logic               timer_go;
    logic               ack;
    logic [WB_DW-1:0]   dat;
    logic               irq;
  } core_s;

  typedef struct packed {
    logic [TIMER_W-1:0] count;
    logic               run;
    logic               done;
  } timer_s;

  localparam core_s  CORE_RESET  = '0;
  localparam timer_s TIMER_RESET = '0;

endpackage

// ### src/nv_prog_timer.sv
`timescale 1ns/100ps
module nv_prog_timer
  import nv_access_pkg::*;
#(
  parameter int CYCLES = WRITE_CYCLES_DEF
)
(
  // Clock, reset, enable
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic ce,
  // Control
  input  wire logic start,
  input  wire logic abort,
  output logic      done
);

  localparam logic [TIMER_W-1:0] LAST = TIMER_W'(CYCLES - 1);

  timer_s st;
  timer_s next_st;

  always_comb
  begin
    next_st = st;
    next_st.done = 1'b0;
    if (abort)
    begin
      next_st.run = 1'b0;
      next_st.count = '0;
    end
    else if (st.run)
    begin
      if (st.count == LAST)
      begin
        next_st.run = 1'b0;
        next_st.done = 1'b1;
        next_st.count = '0;
      end
      else
        next_st.count = st.count + 1'b1;
    end
    else if (start)
      next_st.run = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      st <= TIMER_RESET;
    else if (ce)
      st <= next_st;
  end

  assign done = st.done;

  done_single_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    ce && st.done |=> !st.done)
    else $error("done pulse longer than one cycle");

endmodule

// ### src/nv_byte_array.sv
`timescale 1ns/100ps
module nv_byte_array
  import nv_access_pkg::*;
(
  // Clock and enable
  input  wire logic    sys_clk,
  input  wire logic    ce,
  // Access
  input  wire nv_req_s req,
  output byte_t        rdata
);

  // Unwritten cells read unknown; no erased fill is modelled
  byte_t mem [DEPTH];

  // Erase and program collapse into one store at the end of the timer
  always_ff @(posedge sys_clk)
  begin
    if (ce && req.we)
      mem[req.addr] <= req.wdata;
  end

  assign rdata = mem[req.addr];

endmodule

// ### src/nv_access_ctrl.sv
// Summary of operation
// - Ten-bit address; high register keeps two bits
// - Byte write erases then stores, self-timed
// - Control bit 7 selects program flash
// - Control bit 6 selects configuration space
// - Write enable clears at power-up, gates writes
// - Error flag marks interrupted or improper writes
// - Write start is set-only, hardware clears
// - Completion sets sticky done flag, software clears
// - Read start: one-cycle read, refused off-array
// - Row erase flag cleared by completed erase
// - Unlock port stores nothing, reads zero
// - Select bits kept when an error flags
// - Read data lands next cycle and holds
// - Two-key unlock before every write start
// - Write enable must precede write start
// - Control, data and address registers frozen while a write runs
// - Writes blocked during power-up delay
`timescale 1ns/100ps
module nv_access_ctrl
  import nv_access_pkg::*;
#(
  parameter int WRITE_CYCLES   = WRITE_CYCLES_DEF,
  parameter int POWERUP_CYCLES = POWERUP_CYCLES_DEF
)
(
  // Clock, reset, enable
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic             ce,
  input  wire logic             warm_reset_n,
  // Wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [WB_AW-1:0] wb_adr_i,
  input  wire logic [WB_SW-1:0] wb_sel_i,
  input  wire logic [WB_DW-1:0] wb_dat_i,
  output logic      [WB_DW-1:0] wb_dat_o,
  output logic                  wb_ack_o,
  // Interrupt
  output logic                  irq
);

  localparam logic [PWRUP_W-1:0] PWR_LAST =
    PWRUP_W'(POWERUP_CYCLES - 1);

  core_s            st;
  core_s            next_st;
  nv_req_s          req;
  byte_t            rdata;
  byte_t            rbyte;
  byte_t            wd;
  logic             done;
  logic [IDX_W-1:0] idx;
  logic             bus_wr;
  logic             ctl_wr;
  logic             start_ok;
  logic             flag_clr;

  ////////////////////////////////////////////////////////////
  // Bus decode

  // Writes land on the edge where the master sees ack
  assign idx    = wb_adr_i[WB_AW-1:IDX_LO];
  assign wd     = wb_dat_i[BYTE_W-1:0];
  assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && st.ack
                  && wb_sel_i[BYTE_LANE];
  assign ctl_wr = bus_wr && (idx == REG_CTL)
                  && !st.ctl.write_start;

  assign start_ok = ctl_wr && wd[CTL_WR]
                    && st.ctl.write_enable_flag
                    && (st.unlock == UNLOCK_ARMED)
                    && st.pwr_ok;

  assign flag_clr = bus_wr && (idx == REG_IRQ_FLAGS)
                    && wd[IRQ_DONE_BIT];

  function automatic byte_t ctl_byte(input ctl_s c);
    byte_t b;
    b = '0;
    b[CTL_MEM]  = c.memory_select;
    b[CTL_CFG]  = c.config_select;
    b[CTL_ROW]  = c.row_erase;
    b[CTL_ERR]  = c.write_error_flag;
    b[CTL_WEN]  = c.write_enable_flag;
    b[CTL_WR]   = c.write_start;
    b[CTL_RD]   = c.read_start;
    return b;
  endfunction

  ////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    next_st = st;
    rbyte = '0;
    next_st.timer_go = 1'b0;
    next_st.ack = wb_cyc_i && wb_stb_i && !st.ack;

    // Read mux; reads have no side effects
    case (idx)
      REG_CTL:
        rbyte = ctl_byte(st.ctl);
      REG_UNLOCK:
        rbyte = '0;
      REG_DATA:
        rbyte = st.data;
      REG_ADDR_LO:
        rbyte = st.addr[ADDR_LO_W-1:0];
      REG_ADDR_HI:
        rbyte = BYTE_W'(st.addr[ADDR_W-1:ADDR_LO_W]);
      REG_IRQ_FLAGS:
        rbyte[IRQ_DONE_BIT] = st.irq_flag;
      REG_IRQ_EN:
        rbyte[IRQ_DONE_BIT] = st.irq_en;
      REG_IRQ_PRIO:
        rbyte[IRQ_DONE_BIT] = st.irq_prio;
      default:
        rbyte = '0;
    endcase
    if (next_st.ack)
      next_st.dat = WB_DW'(rbyte);
    else
      next_st.dat = '0;

    // Power-up window; write starts stay refused until it ends
    if (!st.pwr_ok)
    begin
      if (st.pwr_cnt == PWR_LAST)
        next_st.pwr_ok = 1'b1;
      else
        next_st.pwr_cnt = st.pwr_cnt + 1'b1;
    end

    // One-cycle array read
    if (st.ctl.read_start)
    begin
      next_st.data = rdata;
      next_st.ctl.read_start = 1'b0;
    end

    // Self-timed operation finished
    if (done)
    begin
      next_st.ctl.write_start = 1'b0;
      next_st.ctl.write_error_flag = 1'b0;
      if (st.ctl.row_erase)
        next_st.ctl.row_erase = 1'b0;
    end

    // Any other register write breaks the key sequence
    if (bus_wr && (idx != REG_UNLOCK))
      next_st.unlock = UNLOCK_IDLE;

    if (ctl_wr)
    begin
      next_st.ctl.row_erase = wd[CTL_ROW];
      next_st.ctl.write_enable_flag = wd[CTL_WEN];
      // Software may clear the error flag; only a start attempt raises it
      next_st.ctl.write_error_flag =
        st.ctl.write_error_flag && wd[CTL_ERR];
      if (wd[CTL_WR])
      begin
        // Targets stay put on any start attempt
        next_st.ctl.write_error_flag = 1'b1;
        if (start_ok)
        begin
          next_st.ctl.write_start = 1'b1;
          next_st.timer_go = 1'b1;
        end
      end
      else
      begin
        next_st.ctl.memory_select = wd[CTL_MEM];
        next_st.ctl.config_select = wd[CTL_CFG];
        if (wd[CTL_RD] && !wd[CTL_MEM] && !wd[CTL_CFG])
          next_st.ctl.read_start = 1'b1;
      end
    end

    if (bus_wr)
    begin
      case (idx)
        REG_UNLOCK:
          unique case (st.unlock)
            UNLOCK_IDLE,
            UNLOCK_ARMED:
              next_st.unlock = (wd == UNLOCK_KEY1) ?
                UNLOCK_HALF : UNLOCK_IDLE;
            UNLOCK_HALF:
              if (wd == UNLOCK_KEY2)
                next_st.unlock = UNLOCK_ARMED;
              else if (wd == UNLOCK_KEY1)
                next_st.unlock = UNLOCK_HALF;
              else
                next_st.unlock = UNLOCK_IDLE;
            default:
              next_st.unlock = UNLOCK_IDLE;
          endcase
        REG_DATA:
          if (!st.ctl.write_start)
            next_st.data = wd;
        REG_ADDR_LO:
          if (!st.ctl.write_start)
            next_st.addr[ADDR_LO_W-1:0] = wd;
        REG_ADDR_HI:
          if (!st.ctl.write_start)
            next_st.addr[ADDR_W-1:ADDR_LO_W] =
              wd[ADDR_HI_W-1:0];
        REG_IRQ_EN:
          next_st.irq_en = wd[IRQ_DONE_BIT];
        REG_IRQ_PRIO:
          next_st.irq_prio = wd[IRQ_DONE_BIT];
        default:
          next_st.unlock = next_st.unlock;
      endcase
    end

    // Sticky completion flag; a new completion beats the clear
    next_st.irq_flag = (st.irq_flag && !flag_clr) || done;

    // Warm reset keeps the error flag and targets for tracing
    if (!warm_reset_n)
    begin
      next_st.ctl.write_start = 1'b0;
      next_st.ctl.read_start = 1'b0;
      next_st.ctl.write_enable_flag = 1'b0;
      next_st.ctl.row_erase = 1'b0;
      next_st.unlock = UNLOCK_IDLE;
      next_st.timer_go = 1'b0;
      next_st.irq_flag = 1'b0;
      next_st.irq_en = 1'b0;
      next_st.irq_prio = 1'b0;
    end

    next_st.irq = next_st.irq_flag && next_st.irq_en;
  end

  // Power-on reset clears write enable and the power-up window
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      st <= CORE_RESET;
    else if (ce)
      st <= next_st;
  end

  assign wb_dat_o = st.dat;
  assign wb_ack_o = st.ack;
  assign irq      = st.irq;

  ////////////////////////////////////////////////////////////
  // Array and programming timer

  // Only the data array is stored; flash targets just run the timer
  always_comb
  begin
    req.we    = done && warm_reset_n
                && !st.ctl.memory_select
                && !st.ctl.config_select;
    req.addr  = st.addr;
    req.wdata = st.data;
  end

  nv_byte_array u_array (
    .sys_clk (sys_clk),
    .ce      (ce),
    .req     (req),
    .rdata   (rdata)
  );

  nv_prog_timer #(
    .CYCLES (WRITE_CYCLES)
  ) u_timer (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .ce      (ce),
    .start   (st.timer_go),
    .abort   (!warm_reset_n),
    .done    (done)
  );

  ////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  rd_done_a: assert property (
    ce && st.ctl.read_start && !bus_wr
    |=> !st.ctl.read_start && st.data == $past(rdata))
    else $error("read data not loaded after one cycle");

  rd_refuse_a: assert property (
    ce && ctl_wr && (wd[CTL_MEM] || wd[CTL_CFG])
    |=> !st.ctl.read_start)
    else $error("read started while off the data array");

  wr_unlock_a: assert property (
    $rose(st.ctl.write_start)
    |-> $past(st.unlock) == UNLOCK_ARMED)
    else $error("write started without unlock keys");

  wr_prior_en_a: assert property (
    $rose(st.ctl.write_start)
    |-> $past(st.ctl.write_enable_flag) && st.ctl.write_error_flag)
    else $error("write started without prior enable");

  wr_freeze_a: assert property (
    ce && st.ctl.write_start
    |=> $stable(st.addr) && $stable(st.data)
        && $stable(st.ctl.memory_select))
    else $error("address or data changed during write");

  pwrup_block_a: assert property (
    !st.pwr_ok |-> !st.ctl.write_start)
    else $error("write running inside power-up window");

  wr_clear_a: assert property (
    ce && done && warm_reset_n
    |=> !st.ctl.write_start && !st.ctl.write_error_flag)
    else $error("write start or error not cleared on done");

  irq_set_a: assert property (
    ce && done && warm_reset_n |=> st.irq_flag && irq == st.irq_en)
    else $error("completion flag not set");

  err_trace_a: assert property (
    $rose(st.ctl.write_error_flag)
    |-> $stable(st.ctl.memory_select) && $stable(st.ctl.config_select))
    else $error("select bits moved when error flagged");

  unlock_read_a: assert property (
    wb_ack_o && idx == REG_UNLOCK |-> wb_dat_o == '0)
    else $error("unlock port read nonzero");

  addr_high_a: assert property (
    wb_ack_o && idx == REG_ADDR_HI
    |-> wb_dat_o[BYTE_W-1:ADDR_HI_W] == '0)
    else $error("address high upper bits not zero");

  ack_drop_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  read_done_c: cover property (ce && st.ctl.read_start);
  write_done_c: cover property (ce && done && req.we);
  bad_start_c: cover property (
    $rose(st.ctl.write_error_flag) && !st.ctl.write_start);
  irq_seen_c: cover property ($rose(irq));

endmodule

// ### sim/firmware_bus.sv
`timescale 1ns/100ps
module firmware_bus
  import nv_access_pkg::*;
(
  // Clock
  input  wire logic             sys_clk,
  // Wishbone master side
  output logic                  wb_cyc_o,
  output logic                  wb_stb_o,
  output logic                  wb_we_o,
  output logic      [WB_AW-1:0] wb_adr_o,
  output logic      [WB_SW-1:0] wb_sel_o,
  output logic      [WB_DW-1:0] wb_dat_o,
  input  wire logic [WB_DW-1:0] wb_dat_i,
  input  wire logic             wb_ack_i
);
  initial
  begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o  = 1'b0;
    wb_adr_o = '0;
    wb_sel_o = '0;
    wb_dat_o = '0;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic we, input logic [IDX_W-1:0] idx,
                     input byte_t wd, output byte_t rd);
    int n;
    @(posedge sys_clk);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= we;
    wb_adr_o <= {idx, 2'b00};
    wb_sel_o <= 4'h1;
    wb_dat_o <= {24'h000000, wd};
    for (n = 0; n < 20; n++)
    begin
      @(posedge sys_clk);
      if (wb_ack_i === 1'b1)
        break;
    end
    if (n == 20)
      nv_access_ctrl_tb.hang();
    rd = wb_dat_i[7:0];
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    // Released address and data lines flip so stale values are never mistaken as held
    wb_adr_o <= ~wb_adr_o;
    wb_dat_o <= ~wb_dat_o;
  endtask

  task automatic reg_write(input logic [IDX_W-1:0] idx, input byte_t d);
    byte_t x;
    bus(1'b1, idx, d, x);
  endtask

  task automatic reg_read(input logic [IDX_W-1:0] idx, output byte_t d);
    bus(1'b0, idx, 8'h00, d);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic load(input logic [ADDR_W-1:0] a, input byte_t d);
    reg_write(REG_ADDR_LO, a[7:0]);
    reg_write(REG_ADDR_HI, {6'h00, a[9:8]});
    reg_write(REG_DATA, d);
  endtask

  // Keys are given afresh for every byte
  task automatic start(input byte_t c);
    reg_write(REG_UNLOCK, UNLOCK_KEY1);
    reg_write(REG_UNLOCK, UNLOCK_KEY2);
    reg_write(REG_CTL, c);
  endtask

  task automatic wait_idle;
    byte_t c;
    int n;
    c = 8'h02;
    for (n = 0; n < 40 && c[CTL_WR]; n++)
      reg_read(REG_CTL, c);
    if (c[CTL_WR] !== 1'b0)
      nv_access_ctrl_tb.hang();
  endtask

  task automatic ee_write(input logic [ADDR_W-1:0] a, input byte_t d);
    load(a, d);
    reg_write(REG_CTL, 8'h04);
    start(8'h06);
    wait_idle();
  endtask

  task automatic ee_read(input logic [ADDR_W-1:0] a, output byte_t d);
    reg_write(REG_ADDR_LO, a[7:0]);
    reg_write(REG_ADDR_HI, {6'h00, a[9:8]});
    reg_write(REG_CTL, 8'h01);
    reg_read(REG_DATA, d);
  endtask
endmodule

// ### sim/nv_access_ctrl_tb.sv
`timescale 1ns/100ps
module nv_access_ctrl_tb
  import nv_access_pkg::*;
;
  // Short counts keep the run brief
  localparam int WCYC = 32;
  localparam int PCYC = 60;

  logic             sys_clk;
  logic             reset_n;
  logic             ce;
  logic             warm_reset_n;
  logic             wb_cyc;
  logic             wb_stb;
  logic             wb_we;
  logic [WB_AW-1:0] wb_adr;
  logic [WB_SW-1:0] wb_sel;
  logic [WB_DW-1:0] wb_wdat;
  logic [WB_DW-1:0] wb_rdat;
  logic             wb_ack;
  logic             irq;
  int               miscompares = 0;
  int               n_tests = 0;

  initial
    sys_clk = 1'b0;
  always
    #10 sys_clk = ~sys_clk;

  nv_access_ctrl #(.WRITE_CYCLES(WCYC), .POWERUP_CYCLES(PCYC))
    nv_access_ctrl_i (.sys_clk(sys_clk), .reset_n(reset_n), .ce(ce),
    .warm_reset_n(warm_reset_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .irq(irq));

  firmware_bus firmware_bus_i (.sys_clk(sys_clk), .wb_cyc_o(wb_cyc),
    .wb_stb_o(wb_stb), .wb_we_o(wb_we), .wb_adr_o(wb_adr),
    .wb_sel_o(wb_sel), .wb_dat_o(wb_wdat), .wb_dat_i(wb_rdat),
    .wb_ack_i(wb_ack));

  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic hang;
    miscompares++;
    $display("BAD %0t bus or write never finished", $time);
    print_verdict();
  endtask

  task automatic check(input byte_t got, input byte_t exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_check(input logic [IDX_W-1:0] idx, input byte_t exp);
    byte_t v;
    firmware_bus_i.reg_read(idx, v);
    check(v, exp);
  endtask

  // Sampled mid-cycle so the edge's own update has landed
  task automatic irq_check(input logic e);
    @(negedge sys_clk);
    check({7'h00, irq}, {7'h00, e});
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    byte_t v;
    reset_n = 1'b0;
    ce = 1'b1;
    warm_reset_n = 1'b1;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd_check(REG_CTL, 8'h00);
    firmware_bus_i.reg_write(REG_UNLOCK, 8'h55);
    rd_check(REG_UNLOCK, 8'h00);
    firmware_bus_i.reg_write(REG_ADDR_HI, 8'hFF);
    rd_check(REG_ADDR_HI, 8'h03);
    firmware_bus_i.reg_write(4'h9, 8'hFF);
    rd_check(4'h9, 8'h00);
    firmware_bus_i.reg_write(REG_CTL, 8'h04);
    firmware_bus_i.start(8'h06);
    rd_check(REG_CTL, 8'h0C);
    repeat (PCYC) @(posedge sys_clk);
    firmware_bus_i.reg_write(REG_IRQ_EN, 8'h10);
    rd_check(REG_IRQ_EN, 8'h10);
    firmware_bus_i.reg_write(REG_IRQ_PRIO, 8'hFF);
    rd_check(REG_IRQ_PRIO, 8'h10);
    firmware_bus_i.ee_write(10'h3FF, 8'hA5);
    irq_check(1'b1);
    rd_check(REG_IRQ_FLAGS, 8'h10);
    firmware_bus_i.reg_write(REG_IRQ_FLAGS, 8'h10);
    rd_check(REG_IRQ_FLAGS, 8'h00);
    irq_check(1'b0);
    // Changes made while a write runs must not reach the array
    firmware_bus_i.load(10'h0FF, 8'h3C);
    firmware_bus_i.reg_write(REG_CTL, 8'h04);
    firmware_bus_i.start(8'h06);
    rd_check(REG_CTL, 8'h0E);
    firmware_bus_i.reg_write(REG_CTL, 8'h00);
    firmware_bus_i.reg_write(REG_DATA, 8'h00);
    firmware_bus_i.reg_write(REG_ADDR_LO, 8'h00);
    rd_check(REG_CTL, 8'h0E);
    // Low clock enable must hold the timer mid-write
    @(posedge sys_clk);
    ce <= 1'b0;
    repeat (WCYC + 8) @(posedge sys_clk);
    ce <= 1'b1;
    rd_check(REG_CTL, 8'h0E);
    firmware_bus_i.wait_idle();
    rd_check(REG_CTL, 8'h04);
    firmware_bus_i.ee_read(10'h3FF, v);
    check(v, 8'hA5);
    rd_check(REG_DATA, 8'hA5);
    firmware_bus_i.ee_read(10'h0FF, v);
    check(v, 8'h3C);
    firmware_bus_i.reg_write(REG_CTL, 8'h81);
    rd_check(REG_CTL, 8'h80);
    firmware_bus_i.reg_write(REG_CTL, 8'h06);
    rd_check(REG_CTL, 8'h8C);
    firmware_bus_i.reg_write(REG_CTL, 8'h41);
    rd_check(REG_CTL, 8'h40);
    rd_check(REG_DATA, 8'h3C);
    firmware_bus_i.reg_write(REG_CTL, 8'h00);
    firmware_bus_i.start(8'h06);
    rd_check(REG_CTL, 8'h0C);
    firmware_bus_i.load(10'h3FF, 8'h11);
    firmware_bus_i.reg_write(REG_CTL, 8'h94);
    firmware_bus_i.start(8'h96);
    firmware_bus_i.wait_idle();
    rd_check(REG_CTL, 8'h84);
    firmware_bus_i.ee_read(10'h3FF, v);
    check(v, 8'hA5);
    // Keys in the wrong order must not arm a start
    firmware_bus_i.reg_write(REG_CTL, 8'h04);
    firmware_bus_i.reg_write(REG_UNLOCK, UNLOCK_KEY2);
    firmware_bus_i.reg_write(REG_UNLOCK, UNLOCK_KEY1);
    firmware_bus_i.reg_write(REG_CTL, 8'h06);
    rd_check(REG_CTL, 8'h0C);
    firmware_bus_i.reg_write(REG_CTL, 8'h04);
    firmware_bus_i.start(8'h06);
    @(posedge sys_clk);
    warm_reset_n <= 1'b0;
    @(posedge sys_clk);
    warm_reset_n <= 1'b1;
    rd_check(REG_CTL, 8'h08);
    irq_check(1'b0);
    print_verdict();
  end
endmodule
